// *** src/fog_map.svh ***
`ifndef FOG_MAP_SVH
`define FOG_MAP_SVH
// register indices; byte address is four times the index
`define FOG_IDX_CLKDIV  5'h00
`define FOG_IDX_FLASH_STATUS_REGISTER   5'h01
`define FOG_IDX_CMD     5'h02
`define FOG_IDX_INTSTAT 5'h04
`define FOG_IDX_INTCLR  5'h05
`define FOG_IDX_INTEN   5'h06
`define FOG_IDX_VERSION 5'h07
`define FOG_IDX_RSV_C   5'h0C
`define FOG_IDX_RSV_D   5'h0D
`define FOG_IDX_OPTION  5'h0E
`define FOG_IDX_RSV_E   5'h10
`define FOG_IDX_RSV_F   5'h11
`define FOG_IDX_RSV_G   5'h13
// field positions
`define FOG_CLKDIV_LD_BIT  7
`define FOG_FLASH_STATUS_REGISTER_ACC_BIT  5
`define FOG_FLASH_STATUS_REGISTER_PV_BIT   4
`define FOG_FLASH_STATUS_REGISTER_SS_BIT   7
`define FOG_FLASH_STATUS_REGISTER_OPT_BIT  6
`define FOG_VER_NUM_MSB    3
`define FOG_VER_PRES_BIT   16
`define FOG_INT_DIVLD_BIT  0
`define FOG_INT_REFUSE_BIT 1
`define FOG_INT_START_BIT  2
// reset, option-fault and no-version values
`define FOG_RST_BYTE    8'h00
`define FOG_RST_INT     3'h0
`define FOG_OPT_FAULT   8'hFF
`define FOG_VER_NONE_LO 4'h0
`define FOG_VER_NONE_HI 4'hF
`endif

// *** src/fog_pkg.sv ***
package fog_pkg;
  typedef enum logic [1:0] {
    FOG_ST_LOAD = 2'b01,
    FOG_ST_RUN  = 2'b10
  } fog_state_t;
  typedef logic [7:0] fog_byte_t;
endpackage

// *** src/fog_div_if.sv ***
`timescale 1ns/1ps
interface fog_div_if #(parameter int DIV_W = 7);
  logic [DIV_W-1:0] divValue;
  logic             divLoaded;
  logic             tick;
  modport ctrl (output divValue, output divLoaded, input tick);
  modport div  (input divValue, input divLoaded, output tick);
endinterface

// *** src/fog_clk_div.sv ***
`timescale 1ns/1ps
module fog_clk_div
  import fog_pkg::*;
#(
  parameter int DIV_W = 7
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // divider link
  fog_div_if.div    dv
);
  logic [DIV_W-1:0] count;
  logic             tickQ;
  wire              wrap = (count >= dv.divValue);

  assign dv.tick = tickQ;

  // one enable pulse every divValue+1 bus clocks, silent until loaded
  always_ff @(posedge clk) begin
    if (!rst_b || !dv.divLoaded) begin
      count <= '0;
      tickQ <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + 1'b1;
      tickQ <= wrap;
    end
  end
endmodule

// *** src/fog_flash_gate.sv ***
// Behaviour
// - reserved factory-test registers read zero and ignore writes
// - option register is readable; writes to it are discarded
// - option register loads from nonvolatile option byte during reset sequence
// - double-bit fault on that read sets every option bit to one
// - mode input: 0 normal, 1 special; gates divider writes and commands
// - 16-bit version word, number in bits 3..0, bits 15..4 reserved
// - flash timing clock is the bus clock divided per divider register
// - writing the divider register sets the divider-loaded flag
// - divider-loaded flag reads zero until written after reset
// - program or erase launched without divider refused, access error set
`timescale 1ns/1ps
`include "fog_map.svh"
module fog_flash_gate
  import fog_pkg::*;
#(
  parameter int          DIV_W        = 7,
  parameter logic [15:0] VERSION_WORD = 16'h0002 // arbitrary value
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // nonvolatile option fetch
  input  wire logic        nvReadDone,
  input  wire logic        nvDoubleFault,
  input  wire logic [7:0]  optionByteBits,
  // mode and controller events
  input  wire logic        specialModeInput,
  input  wire logic        protViolEvent,
  // controller side
  output logic             cmdStart,
  output logic      [7:0]  cmdCode,
  output logic             flashTimingTick,
  output logic      [7:0]  optionBits,
  output logic             accessErrorFlag,
  output logic             protectionViolationFlag,
  output logic             irq
);
  fog_div_if #(.DIV_W(DIV_W)) dv ();
  fog_clk_div #(.DIV_W(DIV_W)) uDiv (
    .clk   (clk),
    .rst_b (rst_b),
    .dv    (dv)
  );

  fog_state_t       state;
  logic [DIV_W-1:0] divValue;
  logic             divLoaded;
  logic [2:0]       intStatus;
  logic [2:0]       intEnable;

  assign dv.divValue  = divValue;
  assign dv.divLoaded = divLoaded;

  // codes that spend flash timing; all of them need the divider
  function automatic logic isProgErase(input logic [7:0] c);
    return (c == 8'h06) || (c == 8'h07) || (c == 8'h08) || (c == 8'h09) ||
           (c == 8'h0A) || (c == 8'h0B) || (c == 8'h11) || (c == 8'h12);
  endfunction

  function automatic logic cmdInMode(input logic [7:0] c, input logic ss);
    logic known;
    known = ((c >= 8'h01) && (c <= 8'h0E) && (c != 8'h05)) ||
            ((c >= 8'h10) && (c <= 8'h12));
    if (ss)
      return known && (c != 8'h0C);
    return known && (c != 8'h08) && (c != 8'h0B) && (c != 8'h0E);
  endfunction

  // bus decode; a write lands on the edge that samples ack high
  wire        busReq   = wb_cyc_i && wb_stb_i;
  wire [4:0]  idx      = wb_adr_i[6:2];
  wire        inRange  = (wb_adr_i[7] == 1'b0);
  wire        wrStrobe = busReq && wb_ack_o && wb_we_i && wb_sel_i[0] && inRange;
  wire        wrDiv    = wrStrobe && (idx == `FOG_IDX_CLKDIV);
  wire        wrStat   = wrStrobe && (idx == `FOG_IDX_FLASH_STATUS_REGISTER);
  wire        wrCmd    = wrStrobe && (idx == `FOG_IDX_CMD);
  wire        wrIntClr = wrStrobe && (idx == `FOG_IDX_INTCLR);
  wire        wrIntEn  = wrStrobe && (idx == `FOG_IDX_INTEN);
  wire [7:0]  wrByte   = wb_dat_i[7:0];

  // normal mode allows one divider write per reset, special mode any number
  wire        divAccept = wrDiv && (specialModeInput || !divLoaded);

  // command screening
  wire        cmdPE     = isProgErase(wrByte);
  wire        cmdBad    = (state != FOG_ST_RUN) ||
                          !cmdInMode(wrByte, specialModeInput) ||
                          (cmdPE && !divLoaded) ||
                          accessErrorFlag || protectionViolationFlag;
  wire        cmdRefuse = wrCmd && cmdBad;
  wire        cmdGo     = wrCmd && !cmdBad;

  wire        verPresent = (VERSION_WORD[3:0] != `FOG_VER_NONE_LO) &&
                           (VERSION_WORD[3:0] != `FOG_VER_NONE_HI);

  wire [6:0]  divPad   = 7'(divValue);
  wire [7:0]  divRead  = {divLoaded, divPad};
  wire [7:0]  statRead = {specialModeInput, state == FOG_ST_RUN,
                          accessErrorFlag, protectionViolationFlag, 4'h0};
  wire [31:0] verRead  = {15'h0000, verPresent, 12'h000,
                          VERSION_WORD[`FOG_VER_NUM_MSB:0]};

  // reserved factory-test slots fall through to zero
  wire [31:0] readWord =
    !inRange                       ? 32'h0000_0000 :
    (idx == `FOG_IDX_CLKDIV)       ? {24'h00_0000, divRead} :
    (idx == `FOG_IDX_FLASH_STATUS_REGISTER)        ? {24'h00_0000, statRead} :
    (idx == `FOG_IDX_INTSTAT)      ? {29'h0000_0000, intStatus} :
    (idx == `FOG_IDX_INTEN)        ? {29'h0000_0000, intEnable} :
    (idx == `FOG_IDX_VERSION)      ? verRead :
    (idx == `FOG_IDX_OPTION)       ? {24'h00_0000, optionBits} :
                                     32'h0000_0000;

  wire [2:0]  intEvents = {cmdGo, cmdRefuse, divAccept};
  // set wins over clear
  wire [2:0]  next_intStatus = (intStatus & ~(wrIntClr ? wrByte[2:0] : 3'h0)) | intEvents;
  wire [2:0]  next_intEnable = wrIntEn ? wrByte[2:0] : intEnable;
  wire        next_access_error_flag =
    (accessErrorFlag && !(wrStat && wrByte[`FOG_FLASH_STATUS_REGISTER_ACC_BIT])) || cmdRefuse;
  wire        next_pvFlag =
    (protectionViolationFlag && !(wrStat && wrByte[`FOG_FLASH_STATUS_REGISTER_PV_BIT])) || protViolEvent;

  // single-cycle ack, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq && !wb_ack_o;
      wb_dat_o <= (busReq && !wb_ack_o && !wb_we_i) ? readWord : 32'h0000_0000;
    end
  end

  // option fetch runs once after reset release; no path writes it later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state      <= FOG_ST_LOAD;
      optionBits <= `FOG_RST_BYTE;
    end else begin
      unique case (state)
        FOG_ST_LOAD: begin
          if (nvReadDone) begin
            optionBits <= nvDoubleFault ? `FOG_OPT_FAULT : optionByteBits;
            state      <= FOG_ST_RUN;
          end
        end
        FOG_ST_RUN: begin
          state <= FOG_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divValue  <= '0;
      divLoaded <= 1'b0;
    end else if (divAccept) begin
      divValue  <= wrByte[DIV_W-1:0];
      divLoaded <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      accessErrorFlag         <= 1'b0;
      protectionViolationFlag <= 1'b0;
      cmdStart                <= 1'b0;
      cmdCode                 <= `FOG_RST_BYTE;
    end else begin
      accessErrorFlag         <= next_access_error_flag;
      protectionViolationFlag <= next_pvFlag;
      cmdStart                <= cmdGo;
      if (cmdGo)
        cmdCode <= wrByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      intStatus       <= `FOG_RST_INT;
      intEnable       <= `FOG_RST_INT;
      irq             <= 1'b0;
      flashTimingTick <= 1'b0;
    end else begin
      intStatus       <= next_intStatus;
      intEnable       <= next_intEnable;
      irq             <= |(next_intStatus & next_intEnable);
      flashTimingTick <= dv.tick;
    end
  end

  // helper: cycles between divider ticks
  logic [DIV_W-1:0] tickGap;
  logic             gapValid;
  always_ff @(posedge clk) begin
    if (!rst_b || divAccept) begin
      tickGap  <= '0;
      gapValid <= 1'b0;
    end else begin
      tickGap  <= dv.tick ? '0 : tickGap + 1'b1;
      gapValid <= gapValid || dv.tick;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire rdRsv = wb_ack_o && !wb_we_i && inRange &&
               ((idx == `FOG_IDX_RSV_C) || (idx == `FOG_IDX_RSV_D) ||
                (idx == `FOG_IDX_RSV_E) || (idx == `FOG_IDX_RSV_F) ||
                (idx == `FOG_IDX_RSV_G));

  sequence s_refusedLaunch;
    wrCmd && cmdPE && !divLoaded;
  endsequence
  sequence s_flagAndNoStart;
    accessErrorFlag && !cmdStart ##1 !cmdStart;
  endsequence

  a_rsv_reads_zero: assert property (rdRsv |-> wb_dat_o == 32'h0000_0000)
    else $error("reserved register read nonzero");
  a_opt_write_ignored: assert property (
    wrStrobe && (idx == `FOG_IDX_OPTION) |=> $stable(optionBits))
    else $error("option register changed on write");
  a_opt_load_value: assert property (
    state == FOG_ST_LOAD && nvReadDone && !nvDoubleFault
    |=> optionBits == $past(optionByteBits) && state == FOG_ST_RUN)
    else $error("option byte not loaded");
  a_opt_fault_ones: assert property (
    state == FOG_ST_LOAD && nvReadDone && nvDoubleFault |=> optionBits == `FOG_OPT_FAULT)
    else $error("double fault did not set option bits");
  a_normal_div_lock: assert property (
    wrDiv && !specialModeInput && divLoaded |=> $stable(divValue))
    else $error("divider rewritten in normal mode");
  a_version_read: assert property (
    wb_ack_o && !wb_we_i && inRange && idx == `FOG_IDX_VERSION
    |-> wb_dat_o[3:0] == VERSION_WORD[3:0] && wb_dat_o[15:4] == 12'h000)
    else $error("version word misread");
  a_version_none: assert property (
    wb_ack_o && !wb_we_i && inRange && idx == `FOG_IDX_VERSION
    |-> wb_dat_o[16] == !(wb_dat_o[3:0] == 4'h0 || wb_dat_o[3:0] == 4'hF))
    else $error("version presence wrong");
  a_div_tick_period: assert property (
    dv.tick && gapValid && $stable(divValue) |-> tickGap == divValue)
    else $error("divider period wrong");
  a_div_loaded_set: assert property (
    divAccept |=> divLoaded ##1 divLoaded)
    else $error("divider loaded flag not set");
  a_loaded_after_reset: assert property (!$past(rst_b) |-> !divLoaded)
    else $error("divider loaded flag set after reset");
  a_refuse_no_div: assert property (s_refusedLaunch |=> s_flagAndNoStart)
    else $error("command ran without divider");
  a_opt_hold: assert property (state == FOG_ST_RUN |=> $stable(optionBits))
    else $error("option register changed after load");

  // read-side decode for the checks below
  wire rdAck = wb_ack_o && !wb_we_i && inRange;
  wire rdDiv = rdAck && (idx == `FOG_IDX_CLKDIV);
  wire rdOpt = rdAck && (idx == `FOG_IDX_OPTION);

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // loaded only rises, so unloaded now means unloaded at the data edge
  a_div_unloaded_read: assert property (
    rdDiv && !divLoaded |-> wb_dat_o[`FOG_CLKDIV_LD_BIT] == 1'b0)
    else $error("loaded flag read high before divider write");
  a_opt_readback: assert property (
    rdOpt && $stable(optionBits) |-> wb_dat_o[7:0] == optionBits)
    else $error("option register read mismatch");
  // the divider cannot drop between the write edge and the start pulse
  a_launch_needs_div: assert property (
    cmdStart && isProgErase(cmdCode) |-> divLoaded)
    else $error("program or erase started without divider");
  // a refused launch still leaves a trace for software
  a_refuse_sticky: assert property (
    cmdRefuse |=> intStatus[`FOG_INT_REFUSE_BIT] && accessErrorFlag)
    else $error("refusal not recorded");
  a_tick_needs_div: assert property (!divLoaded |-> !dv.tick)
    else $error("flash tick while divider unloaded");
  a_prot_flag_set: assert property (protViolEvent |=> protectionViolationFlag)
    else $error("protection violation not flagged");
  // irq is registered from the next values, so it tracks the flops exactly
  a_irq_level: assert property (irq == |(intStatus & intEnable))
    else $error("interrupt level disagrees with status");
endmodule

// *** verif/fog_flash_gate_tb.sv ***
`timescale 1ns/1ps
`include "fog_map.svh"
module fog_flash_gate_tb
  import fog_pkg::*;
;
  typedef struct {logic [7:0] adr; logic [31:0] wdat; logic [31:0] exp;} fog_row_t;
  logic        clk           = 1'b0;
  logic        rstB          = 1'b0;
  logic        wbCyc         = 1'b0;
  logic        wbStb         = 1'b0;
  logic        wbWe          = 1'b0;
  logic [7:0]  wbAdr         = 8'h00;
  logic [3:0]  wbSel         = 4'h1;
  logic [31:0] wbDatI        = 32'h0000_0000;
  logic        wbAck;
  logic [31:0] wbDatO;
  logic [31:0] rd;
  logic [31:0] wbDatB;
  logic [31:0] rdB;
  logic        nvReadDone    = 1'b0;
  logic        nvDoubleFault = 1'b0;
  fog_byte_t   optionByte    = 8'h00;
  logic        specialMode   = 1'b0;
  logic        protViol      = 1'b0;
  logic        cmdStart;
  fog_byte_t   cmdCode;
  logic        tick;
  fog_byte_t   optionBits;
  logic        access_error_flag;
  logic        pvFlag;
  logic        irq;
  int          errorCnt      = 0;
  int          nChecks       = 0;
  int          starts        = 0;
  int          n;
  fog_row_t    rows[8];

  fog_flash_gate fog_flash_gate_inst (
    .clk(clk), .rst_b(rstB), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_ack_o(wbAck), .wb_dat_o(wbDatO), .nvReadDone(nvReadDone),
    .nvDoubleFault(nvDoubleFault), .optionByteBits(optionByte), .specialModeInput(specialMode),
    .protViolEvent(protViol), .cmdStart(cmdStart), .cmdCode(cmdCode), .flashTimingTick(tick),
    .optionBits(optionBits), .accessErrorFlag(access_error_flag), .protectionViolationFlag(pvFlag), .irq(irq));

  // second copy carries an all-ones version number, read in step with the first
  fog_flash_gate #(.VERSION_WORD(16'h000F)) fog_flash_gate_inst_b (
    .clk(clk), .rst_b(rstB), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_ack_o(), .wb_dat_o(wbDatB), .nvReadDone(nvReadDone),
    .nvDoubleFault(nvDoubleFault), .optionByteBits(optionByte), .specialModeInput(specialMode),
    .protViolEvent(protViol), .cmdStart(), .cmdCode(), .flashTimingTick(),
    .optionBits(), .accessErrorFlag(), .protectionViolationFlag(), .irq());

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (cmdStart === 1'b1)
      starts++;
  end

  function automatic logic [7:0] a(logic [4:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // holds the request until ack is sampled high, then drops it
  task automatic bus(logic we, logic [7:0] adr, logic [31:0] dat);
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatI <= dat;
    // no local limit; a missing ack is left to the watchdog
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd  = wbDatO;
    rdB = wbDatB;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic rdchk(string what, logic [7:0] adr, logic [31:0] exp);
    bus(1'b0, adr, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  task automatic doReset(logic dbl, fog_byte_t b);
    @(posedge clk);
    rstB          <= 1'b0;
    nvDoubleFault <= dbl;
    optionByte    <= b;
    repeat (20) @(posedge clk);
    rstB <= 1'b1;
    @(posedge clk);
    chk("option in reset", {24'h00_0000, optionBits}, 32'h0000_0000);
    nvReadDone <= 1'b1;
    @(posedge clk);
    nvReadDone <= 1'b0;
    @(posedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    $display("FAIL watchdog expected done seen timeout");
    conclude();
  end

  initial begin
    rows = '{'{a(`FOG_IDX_RSV_C), 32'h0000_00FF, 32'h0000_0000}, '{a(`FOG_IDX_RSV_D), 32'h0000_00FF, 32'h0000_0000},
             '{a(`FOG_IDX_RSV_E), 32'h0000_00FF, 32'h0000_0000}, '{a(`FOG_IDX_RSV_F), 32'h0000_00FF, 32'h0000_0000},
             '{a(`FOG_IDX_RSV_G), 32'h0000_00FF, 32'h0000_0000}, '{a(`FOG_IDX_OPTION), 32'h0000_0033, 32'h0000_005A},
             '{a(`FOG_IDX_VERSION), 32'h0000_000F, 32'h0001_0002}, '{8'h80, 32'h0000_00FF, 32'h0000_0000}};
    doReset(1'b1, 8'h5A);
    chk("fault option", {24'h00_0000, optionBits}, 32'h0000_00FF);
    rdchk("fault option reg", a(`FOG_IDX_OPTION), 32'h0000_00FF);
    doReset(1'b0, 8'h5A);
    chk("option", {24'h00_0000, optionBits}, 32'h0000_005A);
    rdchk("divider unwritten", a(`FOG_IDX_CLKDIV), 32'h0000_0000);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].adr, rows[i].wdat);
      rdchk("table row", rows[i].adr, rows[i].exp);
    end
    bus(1'b0, a(`FOG_IDX_VERSION), 32'h0000_0000);
    chk("version none", rdB, 32'h0000_000F);
    chk("option held", {24'h00_0000, optionBits}, 32'h0000_005A);
    $display("test registers done");
    bus(1'b1, a(`FOG_IDX_INTEN), 32'h0000_0007);
    rdchk("int enable", a(`FOG_IDX_INTEN), 32'h0000_0007);
    bus(1'b1, a(`FOG_IDX_CMD), 32'h0000_0006);
    repeat (2) @(posedge clk);
    chk("access error", {31'h0000_0000, access_error_flag}, 32'h0000_0001);
    chk("starts", starts, 0);
    chk("irq", {31'h0000_0000, irq}, 32'h0000_0001);
    rdchk("status", a(`FOG_IDX_FLASH_STATUS_REGISTER), 32'h0000_0060);
    rdchk("int status", a(`FOG_IDX_INTSTAT), 32'h0000_0002);
    bus(1'b1, a(`FOG_IDX_FLASH_STATUS_REGISTER), 32'h0000_0020);
    bus(1'b1, a(`FOG_IDX_INTCLR), 32'h0000_0007);
    repeat (2) @(posedge clk);
    chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
    chk("access error cleared", {31'h0000_0000, access_error_flag}, 32'h0000_0000);
    $display("test refusal done");
    // 100 MHz bus clock over 100 gives the 1 MHz flash timing clock
    bus(1'b1, a(`FOG_IDX_CLKDIV), 32'h0000_0063);
    rdchk("divider loaded", a(`FOG_IDX_CLKDIV), 32'h0000_00E3);
    rdchk("int divider", a(`FOG_IDX_INTSTAT), 32'h0000_0001);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 300);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1 && n < 300);
    chk("tick period", n, 100);
    bus(1'b1, a(`FOG_IDX_CLKDIV), 32'h0000_0009);
    rdchk("normal rewrite", a(`FOG_IDX_CLKDIV), 32'h0000_00E3);
    @(posedge clk);
    specialMode <= 1'b1;
    bus(1'b1, a(`FOG_IDX_CLKDIV), 32'h0000_0062);
    rdchk("special rewrite", a(`FOG_IDX_CLKDIV), 32'h0000_00E2);
    rdchk("special status", a(`FOG_IDX_FLASH_STATUS_REGISTER), 32'h0000_00C0);
    wbSel <= 4'h0;
    bus(1'b1, a(`FOG_IDX_CLKDIV), 32'h0000_0005);
    wbSel <= 4'h1;
    rdchk("lane off", a(`FOG_IDX_CLKDIV), 32'h0000_00E2);
    $display("test divider done");
    bus(1'b1, a(`FOG_IDX_CMD), 32'h0000_0006);
    repeat (2) @(posedge clk);
    chk("accepted", starts, 1);
    chk("code", {24'h00_0000, cmdCode}, 32'h0000_0006);
    bus(1'b1, a(`FOG_IDX_CMD), 32'h0000_000C);
    repeat (2) @(posedge clk);
    chk("special excluded", {31'h0000_0000, access_error_flag}, 32'h0000_0001);
    chk("no start", starts, 1);
    @(posedge clk);
    protViol <= 1'b1;
    @(posedge clk);
    protViol <= 1'b0;
    repeat (2) @(posedge clk);
    chk("prot viol", {31'h0000_0000, pvFlag}, 32'h0000_0001);
    $display("test commands done");
    doReset(1'b0, 8'hA5);
    chk("option reload", {24'h00_0000, optionBits}, 32'h0000_00A5);
    rdchk("divider after reset", a(`FOG_IDX_CLKDIV), 32'h0000_0000);
    chk("error after reset", {31'h0000_0000, access_error_flag}, 32'h0000_0000);
    chk("viol after reset", {31'h0000_0000, pvFlag}, 32'h0000_0000);
    $display("test reset done");
    conclude();
  end
endmodule
